// ===== rtl/jcl_pkg.sv
//------------------------------------------------------------
// Overview of operation
// [R1] Host holds mode select high five clocks
// [R2] Host walks reset to Shift-IR via idle
// [R3] Host shifts erase instruction LSB first
// [R4] Update-IR makes the shifted instruction active
// [R5] Host shifts configuration-write instruction LSB first
// [R6] Host idles for the power-on wait
// [R7] Data accepted only after memory-cleared indication
// [R8] Host walks idle to Shift-DR
// [R9] Host shifts bitstream MSB first, length minus one
// [R10] Last bit shifts leaving Shift-DR
// [R11] Configuration register shifts MSB first, input to output
// [R12] Host goes Update-DR then idle
// [R13] Startup instruction starts the startup sequence
// [R14] Host applies 2000 idle clocks for startup
// [R15] Three high clocks reach reset; device operational
// [R16] Encrypted streams pause by stopping the clock
// [R17] Stacked devices stay in Shift-DR throughout
// [R18] Chain: target gets config-write, others bypass
// [R19] Chain: startup into all, 2000 idle clocks
// [R20] Bypass bit loads zero in Capture-DR, passes data
// [R21] Only Test-Logic-Reset or power-up resets the TAP
// [R22] Host drives data input to a known level
//------------------------------------------------------------
package jcl_pkg;
  localparam int IR_LEN = 6;
  localparam int CFG_LEN = 32;
  localparam logic [5:0] IR_BYPASS = 6'h3F;
  localparam logic [5:0] IR_CFG_WRITE = 6'h05;
  localparam logic [5:0] IR_ERASE_REPROGRAM = 6'h0B;
  localparam logic [5:0] IR_STARTUP_CLOCK = 6'h0C;
  localparam logic [5:0] IR_CAPTURE_LOW = 6'h01;
  localparam logic [5:0] IR_RESET_VALUE = 6'h3F;
  localparam int CLEAR_CYCLES = 64;
  localparam int STARTUP_TCK = 2000;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jcl_tap_t;
endpackage : jcl_pkg

// ===== rtl/jcl_word_if.sv
`timescale 1ns/1ps
interface jcl_word_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : jcl_word_if

// ===== rtl/jcl_fifo.sv
`timescale 1ns/1ps
module jcl_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  jcl_word_if.dst wr,
  jcl_word_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic full;
  logic empty;
  assign empty = (wp_reg == rp_reg);
  assign full = (wp_reg[AW-1:0] == rp_reg[AW-1:0]) && (wp_reg[AW] != rp_reg[AW]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem_reg[rp_reg[AW-1:0]];
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else if (ce_i)
    begin
      if (wr.valid && !full)
      begin
        mem_reg[wp_reg[AW-1:0]] <= wr.data;
        wp_reg <= wp_reg + 1'b1;
      end
      if (rd.ready && !empty)
        rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule : jcl_fifo

// ===== rtl/jcl_tap_loader.sv
`timescale 1ns/1ps
module jcl_tap_loader
  import jcl_pkg::*;
(
  // System
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // Test access port pins
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  // Configuration memory side
  input wire logic CLEARED_I,
  output logic [31:0] WORD_O,
  output logic WORD_VALID_O,
  input wire logic WORD_READY_I,
  output logic ERASE_O,
  output logic STARTUP_DONE_O,
  output logic [3:0] TAP_STATE_O
);
  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  logic [1:0] tck_s_reg, tms_s_reg, tdi_s_reg, clr_s_reg;
  logic tck_d_reg;
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      tck_s_reg <= '0;
      tms_s_reg <= 2'h3;
      tdi_s_reg <= '0;
      clr_s_reg <= '0;
      tck_d_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      tck_s_reg <= {tck_s_reg[0], TCK_I};
      tms_s_reg <= {tms_s_reg[0], TMS_I};
      tdi_s_reg <= {tdi_s_reg[0], TDI_I};
      clr_s_reg <= {clr_s_reg[0], CLEARED_I};
      tck_d_reg <= tck_s_reg[1];
    end
  end
  logic rise;
  logic fall;
  logic tms;
  logic tdi;
  assign rise = tck_s_reg[1] && !tck_d_reg;
  assign fall = !tck_s_reg[1] && tck_d_reg;
  assign tms = tms_s_reg[1];
  assign tdi = tdi_s_reg[1];

  function automatic jcl_tap_t tap_next(input jcl_tap_t s, input logic m);
    case (s)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UPD_DR : PA_DR;
      PA_DR: tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UPD_DR : SH_DR;
      UPD_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UPD_IR : PA_IR;
      PA_IR: tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UPD_IR : SH_IR;
      UPD_IR: tap_next = m ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction : tap_next

  //------------------------------------------------------------
  // TAP state machine
  //------------------------------------------------------------
  // Reset only by power-up or by walking into TLR; no program pin
  jcl_tap_t st_reg;
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      st_reg <= TLR;
    else if (CE_I && rise)
      st_reg <= tap_next(st_reg, tms); // see [R21]
  end

  //------------------------------------------------------------
  // Instruction register
  //------------------------------------------------------------
  logic [IR_LEN-1:0] ir_sh_reg, ir_reg;
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      ir_sh_reg <= '0;
      ir_reg <= IR_RESET_VALUE;
    end
    else if (CE_I && rise)
    begin
      if (st_reg == CAP_IR)
        ir_sh_reg <= {clr_s_reg[1], 3'h0, IR_CAPTURE_LOW[1:0]};
      else if (st_reg == SH_IR)
        ir_sh_reg <= {tdi, ir_sh_reg[IR_LEN-1:1]}; // see [R3] see [R5]
      if (st_reg == TLR)
        ir_reg <= IR_RESET_VALUE;
      else if (st_reg == UPD_IR)
        ir_reg <= ir_sh_reg; // see [R4]
    end
  end

  //------------------------------------------------------------
  // Bypass and configuration data registers
  //------------------------------------------------------------
  logic byp_reg;
  logic [CFG_LEN-1:0] cfg_sh_reg;
  logic [5:0] cfg_cnt_reg;
  logic accept;
  logic cfg_sel;
  assign cfg_sel = (ir_reg == IR_CFG_WRITE);
  // Data before the memory is cleared is dropped, not buffered
  assign accept = cfg_sel && clr_s_reg[1]; // see [R7]
  jcl_word_if wq ();
  jcl_word_if rq ();
  logic push_reg;
  assign wq.valid = push_reg;
  assign wq.data = cfg_sh_reg;
  assign rq.ready = WORD_READY_I && !WORD_VALID_O;
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      byp_reg <= 1'b0;
      cfg_sh_reg <= '0;
      cfg_cnt_reg <= '0;
      push_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      // One-cycle push: a word that meets a full FIFO is dropped, never replayed later
      if (push_reg)
        push_reg <= 1'b0;
      if (rise)
      begin
        if (st_reg == CAP_DR)
        begin
          byp_reg <= 1'b0; // see [R20]
          cfg_cnt_reg <= '0;
        end
        else if (st_reg == SH_DR)
        begin
          byp_reg <= tdi; // see [R20]
          if (accept)
          begin
            cfg_sh_reg <= {cfg_sh_reg[CFG_LEN-2:0], tdi}; // see [R11]
            cfg_cnt_reg <= (cfg_cnt_reg == 6'(CFG_LEN - 1)) ? 6'h00 : cfg_cnt_reg + 6'h01;
            if (cfg_cnt_reg == 6'(CFG_LEN - 1))
              push_reg <= 1'b1;
          end
        end
      end
    end
  end
  // Full FIFO loses words; host must pace TCK below drain rate
  jcl_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .wr(wq),
    .rd(rq)
  );

  //------------------------------------------------------------
  // Outputs and startup
  //------------------------------------------------------------
  logic [11:0] su_cnt_reg;
  always_ff @(posedge CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      WORD_O <= '0;
      WORD_VALID_O <= 1'b0;
      ERASE_O <= 1'b0;
      STARTUP_DONE_O <= 1'b0;
      su_cnt_reg <= '0;
      TAP_STATE_O <= '0;
      TDO_O <= 1'b0;
      TDO_OE_O <= 1'b0;
    end
    else if (CE_I)
    begin
      TAP_STATE_O <= st_reg;
      if (WORD_VALID_O && WORD_READY_I)
        WORD_VALID_O <= 1'b0;
      else if (rq.valid && rq.ready)
      begin
        WORD_O <= rq.data;
        WORD_VALID_O <= 1'b1;
      end
      ERASE_O <= (ir_reg == IR_ERASE_REPROGRAM) && (st_reg == RTI);
      if (rise && ir_reg == IR_STARTUP_CLOCK && st_reg == RTI && su_cnt_reg != 12'(STARTUP_TCK))
        su_cnt_reg <= su_cnt_reg + 12'h001; // see [R13]
      if (su_cnt_reg == 12'(STARTUP_TCK))
        STARTUP_DONE_O <= 1'b1; // see [R15]
      if (fall)
      begin
        TDO_OE_O <= (st_reg == SH_DR) || (st_reg == SH_IR);
        if (st_reg == SH_IR)
          TDO_O <= ir_sh_reg[0];
        else if (cfg_sel)
          TDO_O <= cfg_sh_reg[CFG_LEN-1]; // see [R11]
        else
          TDO_O <= byp_reg;
      end
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  tlr_force_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R21]
    (CE_I && rise && tms && st_reg == SEL_IR) |=> st_reg == TLR) else $error("no TLR");
  ir_update_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R4]
    (CE_I && rise && st_reg == UPD_IR) |=> ir_reg == $past(ir_sh_reg)) else $error("ir lost");
  byp_cap_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R20]
    (CE_I && rise && st_reg == CAP_DR) |=> !byp_reg) else $error("bypass not zero");
  byp_pass_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R20]
    (CE_I && rise && st_reg == SH_DR) |=> byp_reg == $past(tdi)) else $error("bypass lost");
  cfg_gate_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R7]
    (CE_I && rise && st_reg == SH_DR && !accept) |=> $stable(cfg_sh_reg)) else $error("early data");
  cfg_msb_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R11]
    (CE_I && rise && st_reg == SH_DR && accept) |=> cfg_sh_reg[0] == $past(tdi)) else $error("shift order");
  su_done_a: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [R13]
    (CE_I && su_cnt_reg == 12'(STARTUP_TCK)) |=> STARTUP_DONE_O) else $error("no startup");
endmodule : jcl_tap_loader

// ===== dv/jcl_host_model.sv
`timescale 1ns/1ps
// ----
// Test port host
// ----
module jcl_host_model (
  // Pins
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  logic tdo_seen;
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    tdo_seen = 1'b0;
  end
  // Clock idles low between calls
  task automatic step(input logic m, input logic d);
    tms_o = m;
    tdi_o = d;
    #16;
    tdo_seen = tdo_i;
    tck_o = 1'b1;
    #16;
    tck_o = 1'b0;
  endtask : step
endmodule : jcl_host_model

// ===== dv/tb_jtag_config_load_sequence.sv
`timescale 1ns/1ps
module tb_jtag_config_load_sequence;
  import jcl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cleared = 1'b0;
  logic ready = 1'b0;
  logic tck, tms, tdi, tdo, oe, wvalid, erase, done;
  logic [31:0] word;
  logic [3:0] state;
  logic [31:0] sent[$];
  logic [31:0] got[$];
  int bad_count = 0;
  int compares = 0;
  always #2 clk = ~clk;
  jcl_host_model host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  jcl_tap_loader dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .TCK_I(tck), .TMS_I(tms),
    .TDI_I(tdi), .TDO_O(tdo), .TDO_OE_O(oe), .CLEARED_I(cleared), .WORD_O(word),
    .WORD_VALID_O(wvalid), .WORD_READY_I(ready), .ERASE_O(erase), .STARTUP_DONE_O(done),
    .TAP_STATE_O(state));
  always @(posedge clk)
  begin
    if (wvalid === 1'b1 && ready === 1'b1)
      got.push_back(word);
  end
  // ----
  // Helpers
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic summarize;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  // Words that fit the buffer while the far side stalls; the rest are dropped
  function automatic int kept_words(input int n);
    kept_words = (n < FIFO_DEPTH) ? n : FIFO_DEPTH;
  endfunction : kept_words
  task automatic ld_ir(input logic [5:0] code);
    host.step(1'b1, 1'b0);
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b0);
    host.step(1'b0, 1'b0);
    for (int i = 0; i < 6; i++)
      host.step(i == 5, code[i]);
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b0);
    chk(32'(state), 32'(RTI), "idle");
  endtask : ld_ir
  task automatic to_dr;
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b0);
    host.step(1'b0, 1'b0);
    // Enable follows the detected falling edge, some clocks late
    repeat (4) @(negedge clk);
    chk(32'(oe), 32'h1, "shift enable");
  endtask : to_dr
  // Stays in shift for the whole stream
  task automatic shw(input logic [31:0] w, input logic last);
    for (int i = 31; i >= 0; i--)
      host.step(last && i == 0, w[i]);
  endtask : shw
  task automatic leave;
    host.step(1'b1, 1'b0);
    host.step(1'b0, 1'b0);
  endtask : leave
  // ----
  // Main sequence
  // ----
  initial
  begin
    logic [31:0] w;
    logic prev;
    void'($urandom(32'h9803ebcd));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Far side takes words at once, so a leaked word would show
    ready = 1'b1;
    repeat (5) host.step(1'b1, 1'b0);
    chk(32'(state), 32'(TLR), "reset");
    host.step(1'b0, 1'b0);
    ld_ir(IR_ERASE_REPROGRAM);
    chk(32'(erase), 32'h1, "erase on");
    ld_ir(IR_CFG_WRITE);
    chk(32'(erase), 32'h0, "erase off");
    repeat (8) host.step(1'b0, 1'b0);
    to_dr;
    shw(32'hA5A5A5A5, 1'b1);
    leave;
    chk(32'(got.size()), 32'h0, "refused");
    $display("t1 done");
    @(negedge clk);
    cleared = 1'b1;
    ready = 1'b0;
    to_dr;
    // Far side stalls until all words are in
    for (int k = 0; k < 18; k++)
    begin
      w = $urandom;
      sent.push_back(w);
      shw(w, k == 17);
    end
    leave;
    for (int t = 0; t < 3000 && !(got.size() >= 16 && wvalid === 1'b0); t++)
    begin
      @(negedge clk);
      ready = 1'($urandom);
    end
    chk(32'(wvalid), 32'h0, "drain");
    chk(32'(got.size()), 32'(kept_words(18)), "kept");
    foreach (got[j])
      chk(got[j], sent[j], "word");
    $display("t2 done");
    ld_ir(IR_BYPASS);
    to_dr;
    prev = 1'b0;
    for (int b = 0; b < 16; b++)
    begin
      w[0] = 1'($urandom);
      host.step(b == 15, w[0]);
      chk(32'(host.tdo_seen), 32'(prev), "bypass");
      prev = w[0];
    end
    leave;
    $display("t3 done");
    ld_ir(IR_STARTUP_CLOCK);
    repeat (STARTUP_TCK - 1) host.step(1'b0, 1'b0);
    chk(32'(done), 32'h0, "early");
    host.step(1'b0, 1'b0);
    chk(32'(done), 32'h1, "started");
    repeat (3) host.step(1'b1, 1'b0);
    chk(32'(state), 32'(TLR), "to reset");
    chk(32'(done), 32'h1, "sticky");
    $display("t4 done");
    summarize();
  end
  initial
  begin
    #300000;
    bad_count++;
    summarize();
  end
endmodule : tb_jtag_config_load_sequence
